// ==== tps_defs.svh ====
// constants for the tick prescaler configuration block
`ifndef TPS_DEFS_SVH
`define TPS_DEFS_SVH
`define TPS_OPT_ADDR 8'h81
`define TPS_CNT_ADDR 8'h01
`define TPS_OPT_RESET 8'hFF
`define TPS_CNT_RESET 8'h00
`define TPS_BIT_PU 7
`define TPS_BIT_IEDG 6
`define TPS_BIT_CS 5
`define TPS_BIT_SE 4
`define TPS_BIT_PSA 3
`define TPS_PS_HI 2
`define TPS_PS_LO 0
`endif

// ==== tps_pkg.sv ====
// types for the tick prescaler configuration block
package tps_pkg;
  typedef struct packed {
    logic pu_dis;
    logic irq_edge;
    logic clk_src;
    logic src_edge;
    logic prescaler_assign;
    logic [2:0] rate;
  } tps_opt_t;
endpackage

// ==== tps_top.sv ====
// option register, prescaler and tick counter
`timescale 1ns/100ps
`default_nettype none
`include "tps_defs.svh"
module tps_top #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // port b
  input wire logic [7:0] port_b_latch_i,
  output logic [7:0] port_b_pullup_en_o,
  // external interrupt pin
  input wire logic ext_irq_pin_i,
  output logic ext_irq_event_o,
  // external count clock pin
  input wire logic ext_count_clock_pin_i,
  input wire logic ext_count_clock_drive_low_i,
  output logic ext_count_clock_pin_o,
  output logic ext_count_clock_pin_oe_o,
  // watchdog side
  input wire logic watchdog_tick_i,
  output logic watchdog_timeout_o,
  // counter
  output logic [7:0] tick_counter_o,
  output logic tick_overflow_o
);
  initial begin
    if (ADDR_W < 8) $error("ADDR_W must be at least 8");
  end

  tps_pkg::tps_opt_t opt_reg, opt_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [7:0] pre_reg, pre_next;
  logic [7:0] dat_reg, dat_next;
  logic ack_reg, ack_next;
  logic [2:0] ext_sync_reg, ext_sync_next;
  logic irq_prev_reg, irq_prev_next;
  logic irq_ev_reg, irq_ev_next;
  logic ovf_reg, ovf_next;
  logic wdt_reg, wdt_next;
  logic src_pulse, pre_out, cnt_inc, ext_edge, wb_req, hit_opt, hit_cnt;

  // ratio mask: 2**n - 1
  function automatic logic [7:0] rate_mask(input logic [3:0] n);
    rate_mask = 8'(({8'h00, 8'hFF} << n) >> 8);
  endfunction

  assign wb_req = cyc_i && stb_i && !ack_reg;
  assign hit_opt = adr_i[7:0] == `TPS_OPT_ADDR;
  assign hit_cnt = adr_i[7:0] == `TPS_CNT_ADDR;

  // external pin edge
  always_comb begin
    if (opt_reg.src_edge) begin
      ext_edge = ext_sync_reg[2] && !ext_sync_reg[1];
    end else begin
      ext_edge = !ext_sync_reg[2] && ext_sync_reg[1];
    end
    src_pulse = opt_reg.clk_src ? ext_edge : 1'b1;
  end

  // prescaler shared between counter and watchdog
  always_comb begin
    pre_next = pre_reg;
    pre_out = 1'b0;
    wdt_next = 1'b0;
    if (opt_reg.prescaler_assign) begin
      if (watchdog_tick_i) begin
        if ((pre_reg & rate_mask({1'b0, opt_reg.rate})) == rate_mask({1'b0, opt_reg.rate})) begin
          pre_next = 8'h00;
          wdt_next = 1'b1;
        end else begin
          pre_next = 8'(pre_reg + 8'h01);
        end
      end
    end else if (src_pulse) begin
      if ((pre_reg & rate_mask(4'(opt_reg.rate) + 4'h1)) == rate_mask(4'(opt_reg.rate) + 4'h1)) begin
        pre_next = 8'h00;
        pre_out = 1'b1;
      end else begin
        pre_next = 8'(pre_reg + 8'h01);
      end
    end
    // counter runs undivided when prescaler serves watchdog
    cnt_inc = opt_reg.prescaler_assign ? src_pulse : pre_out;
  end

  // registers and counter next values
  always_comb begin
    opt_next = opt_reg;
    cnt_next = cnt_inc ? 8'(cnt_reg + 8'h01) : cnt_reg;
    ovf_next = cnt_inc && cnt_reg == 8'hFF;
    dat_next = dat_reg;
    ack_next = wb_req;
    ext_sync_next = {ext_sync_reg[1], ext_sync_reg[0], ext_count_clock_pin_i};
    irq_prev_next = ext_irq_pin_i;
    if (opt_reg.irq_edge) begin
      irq_ev_next = ext_irq_pin_i && !irq_prev_reg;
    end else begin
      irq_ev_next = !ext_irq_pin_i && irq_prev_reg;
    end
    if (wb_req) begin
      if (hit_opt) begin
        if (we_i && sel_i[0]) begin
          opt_next = tps_pkg::tps_opt_t'(dat_i[7:0]);
        end
        dat_next = opt_reg;
      end else if (hit_cnt) begin
        if (we_i && sel_i[0]) begin
          cnt_next = dat_i[7:0];
        end
        dat_next = cnt_reg;
      end else begin
        dat_next = 8'h00;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    // pin history runs through reset, so no false edge follows it
    ext_sync_reg <= ext_sync_next;
    irq_prev_reg <= irq_prev_next;
    if (rst_i) begin
      opt_reg <= tps_pkg::tps_opt_t'(`TPS_OPT_RESET);
      cnt_reg <= `TPS_CNT_RESET;
      pre_reg <= 8'h00;
      dat_reg <= 8'h00;
      ack_reg <= 1'b0;
      irq_ev_reg <= 1'b0;
      ovf_reg <= 1'b0;
      wdt_reg <= 1'b0;
    end else begin
      opt_reg <= opt_next;
      cnt_reg <= cnt_next;
      pre_reg <= pre_next;
      dat_reg <= dat_next;
      ack_reg <= ack_next;
      irq_ev_reg <= irq_ev_next;
      ovf_reg <= ovf_next;
      wdt_reg <= wdt_next;
    end
  end

  assign port_b_pullup_en_o = opt_reg.pu_dis ? 8'h00 : port_b_latch_i;
  assign ext_count_clock_pin_o = 1'b0;
  assign ext_count_clock_pin_oe_o = ext_count_clock_drive_low_i;
  assign dat_o = {24'h000000, dat_reg};
  assign ack_o = ack_reg;
  assign tick_counter_o = cnt_reg;
  assign tick_overflow_o = ovf_reg;
  assign ext_irq_event_o = irq_ev_reg;
  assign watchdog_timeout_o = wdt_reg;

  pullup_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    opt_reg.pu_dis |-> port_b_pullup_en_o == 8'h00)
    else $error("pull-ups on while disabled");
  irq_rise_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $stable(opt_reg.irq_edge) && opt_reg.irq_edge && $rose(ext_irq_pin_i) |=> ext_irq_event_o)
    else $error("rising edge interrupt missed");
  int_src_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !opt_reg.clk_src && opt_reg.prescaler_assign && !(wb_req && hit_cnt && we_i) |=> tick_counter_o == 8'($past(cnt_reg) + 8'h01))
    else $error("counter not following instruction clock");
  ext_fall_a: assert property (@(posedge clk_i) disable iff (rst_i)
    opt_reg.clk_src && opt_reg.src_edge && !ext_sync_reg[1] && ext_sync_reg[2] |-> src_pulse)
    else $error("falling count edge lost");
  wdt_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    opt_reg.prescaler_assign |-> !pre_out)
    else $error("prescaler feeds counter while on watchdog");
  tick_div_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !opt_reg.prescaler_assign && !opt_reg.clk_src && opt_reg.rate == 3'h0 && $stable(opt_reg) |-> pre_out != $past(pre_out))
    else $error("1:2 prescale wrong");
  wdt_div_a: assert property (@(posedge clk_i) disable iff (rst_i)
    opt_reg.prescaler_assign && opt_reg.rate == 3'h0 && watchdog_tick_i |=> watchdog_timeout_o)
    else $error("1:1 postscale wrong");
  pin_od_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ext_count_clock_pin_oe_o |-> !ext_count_clock_pin_o)
    else $error("count pin driven high");
  sync_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ext_sync_reg[1] == $past(ext_count_clock_pin_i, 2))
    else $error("synchroniser depth wrong");

  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o
    |=> !ack_o)
    else $error("ack longer than one cycle");

  ack_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && !ack_o
    |=> ack_o)
    else $error("request not acknowledged");

  ack_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(cyc_i && stb_i)
    |=> !ack_o)
    else $error("ack without request");

  opt_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_req && hit_opt && we_i && sel_i[0]
    |=> opt_reg == tps_pkg::tps_opt_t'($past(dat_i[7:0])))
    else $error("option write lost");

  opt_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_req && hit_opt && !we_i
    |=> dat_o[7:0] == $past(opt_reg))
    else $error("option read wrong");

  unmapped_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_req && !hit_opt && !hit_cnt
    |=> dat_o == 32'h00000000)
    else $error("unmapped read not zero");

  dat_upper_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o
    |-> dat_o[31:8] == 24'h000000)
    else $error("upper read bits not zero");

  opt_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wb_req && hit_opt && we_i && sel_i[0])
    |=> $stable(opt_reg))
    else $error("option changed without write");

  pullup_pass_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !opt_reg.pu_dis
    |-> port_b_pullup_en_o == port_b_latch_i)
    else $error("pull-ups not following latch");

  irq_fall_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $stable(opt_reg.irq_edge) && !opt_reg.irq_edge && $fell(ext_irq_pin_i)
    |=> ext_irq_event_o)
    else $error("falling edge interrupt missed");

  irq_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ext_irq_event_o && $stable(opt_reg.irq_edge)
    |=> !ext_irq_event_o)
    else $error("interrupt event too long");

  irq_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $stable(ext_irq_pin_i)
    |=> !ext_irq_event_o)
    else $error("interrupt event without edge");

  sync_shift_a: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1
    |-> ext_sync_reg[2] == $past(ext_sync_reg[1]))
    else $error("synchroniser stage skipped");

  ext_rise_a: assert property (@(posedge clk_i) disable iff (rst_i)
    opt_reg.clk_src && !opt_reg.src_edge && ext_sync_reg[1] && !ext_sync_reg[2]
    |-> src_pulse)
    else $error("rising count edge lost");

  ext_none_a: assert property (@(posedge clk_i) disable iff (rst_i)
    opt_reg.clk_src && ext_sync_reg[1] == ext_sync_reg[2]
    |-> !src_pulse)
    else $error("count pulse without pin edge");

  int_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !opt_reg.clk_src
    |-> src_pulse)
    else $error("instruction clock pulse missing");

  cnt_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    opt_reg.prescaler_assign && opt_reg.clk_src && ext_sync_reg[1] == ext_sync_reg[2] && !(wb_req && hit_cnt && we_i)
    |=> $stable(tick_counter_o))
    else $error("counter moved without pin edge");

  cnt_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_req && hit_cnt && we_i && sel_i[0]
    |=> tick_counter_o == $past(dat_i[7:0]))
    else $error("counter write lost");

  ovf_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cnt_inc && cnt_reg == 8'hFF && !(wb_req && hit_cnt && we_i)
    |=> tick_overflow_o && tick_counter_o == 8'h00)
    else $error("overflow not flagged");

  ovf_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !cnt_inc
    |=> !tick_overflow_o)
    else $error("overflow without increment");

  wdt_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(opt_reg.prescaler_assign && watchdog_tick_i)
    |=> !watchdog_timeout_o)
    else $error("watchdog pulse without tick");

  tick_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !opt_reg.prescaler_assign && !src_pulse
    |-> !pre_out)
    else $error("prescaler output without source pulse");

  pin_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ext_count_clock_drive_low_i
    |-> !ext_count_clock_pin_oe_o)
    else $error("count pin driven while released");
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the tick prescaler configuration block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic irq_pin = 0, cnt_pin = 0, drv_lo = 0, wd_tick = 0;
  logic [7:0] adr_i = 0, latch = 0, cnt_o, pu_en;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 0, dat_o, rd;
  logic ack_o, irq_ev, pin_o, pin_oe, wd_to, ovf;
  int num_errors = 0, tests_run = 0, seed = 82, irq_n = 0, wd_n = 0, ovf_n = 0, c0, m;
  always #50 clk_i = ~clk_i;
  tps_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .port_b_latch_i(latch),
    .port_b_pullup_en_o(pu_en), .ext_irq_pin_i(irq_pin), .ext_irq_event_o(irq_ev),
    .ext_count_clock_pin_i(cnt_pin), .ext_count_clock_drive_low_i(drv_lo), .ext_count_clock_pin_o(pin_o),
    .ext_count_clock_pin_oe_o(pin_oe), .watchdog_tick_i(wd_tick), .watchdog_timeout_o(wd_to),
    .tick_counter_o(cnt_o), .tick_overflow_o(ovf));
  always @(posedge clk_i) begin
    irq_n <= irq_n + irq_ev;
    wd_n <= wd_n + wd_to;
    ovf_n <= ovf_n + ovf;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
    @(posedge clk_i);
  endtask
  task automatic print_verdict;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #1000000;
    num_errors++;
    print_verdict();
  end
  initial begin
    tk(6);
    rst_i <= 0;
    tk(1);
    wb(0, 8'h81, 0);
    chk(rd, 32'h000000FF);
    wb(0, 8'h55, 0);
    chk(rd, 32'h00000000);
    repeat (4) begin
      m = $random(seed);
      latch <= m[15:8];
      drv_lo <= m[16];
      wb(1, 8'h81, m[7:0]);
      wb(0, 8'h81, 0);
      chk(rd, m & 32'hFF);
      chk(pu_en, m[7] ? 8'h00 : m[15:8]);
      chk({pin_oe, pin_o}, {m[16], 1'b0});
    end
    for (int e = 0; e < 2; e++) begin
      wb(1, 8'h81, 8'(15 + 64 * e));
      c0 = irq_n;
      irq_pin <= 1;
      tk(6);
      chk(irq_n - c0, e);
      irq_pin <= 0;
      tk(6);
      chk(irq_n - c0, 1);
    end
    for (int n = 0; n < 8; n++) begin
      wb(1, 8'h81, 8'(n));
      tk(2);
      c0 = cnt_o;
      tk(4 << n);
      chk(8'(cnt_o - c0), 2);
    end
    wb(1, 8'h81, 8'h08);
    tk(2);
    c0 = cnt_o;
    tk(100);
    chk(8'(cnt_o - c0), 100);
    for (int n = 0; n < 8; n++) begin
      wb(1, 8'h81, 8'(40 + n));
      c0 = wd_n;
      repeat (2 << n) begin
        wd_tick <= 1;
        tk(1);
        wd_tick <= 0;
        tk(1);
      end
      tk(4);
      chk(wd_n - c0, 2);
    end
    for (int e = 0; e < 2; e++) begin
      wb(1, 8'h81, 8'(40 + 16 * e));
      tk(4);
      c0 = cnt_o;
      cnt_pin <= 1;
      tk(5);
      cnt_pin <= 0;
      tk(5);
      cnt_pin <= 1;
      tk(6);
      chk(8'(cnt_o - c0), e ? 1 : 2);
      cnt_pin <= 0;
      tk(6);
    end
    wb(1, 8'h01, 8'hFF);
    wb(0, 8'h01, 0);
    chk(rd, 32'h000000FF);
    c0 = ovf_n;
    cnt_pin <= 1;
    tk(6);
    cnt_pin <= 0;
    tk(6);
    chk(ovf_n - c0, 1);
    chk(cnt_o, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
